// *** design/asw_pkg.sv ***
package asw_pkg;
    // register offsets as seen by the serial port
    localparam logic [7:0] OFS_CAUTION = 8'h26;
    localparam logic [7:0] OFS_TEMP = 8'h28;
    localparam logic [7:0] OFS_FIELD = 8'h2a;
    localparam logic [7:0] OFS_TURNS = 8'h2c;

    // hard-coded register identifiers
    localparam logic [3:0] ID_CAUTION = 4'hb;
    localparam logic [3:0] ID_TEMP = 4'hf;
    localparam logic [3:0] ID_FIELD = 4'he;
    localparam logic [2:0] ID_TURNS = 3'h6;

    // caution flag bit positions
    localparam int B_IFACE = 11;
    localparam int B_CRC = 10;
    localparam int B_ZERO = 9;
    localparam int B_RATE = 8;
    localparam int B_EXT = 7;
    localparam int B_TEMP = 6;
    localparam int B_EE = 5;
    localparam int B_CLIP = 4;
    localparam int B_ROT = 3;
    localparam int B_BUSY = 2;
    localparam int B_FIELD = 1;
    localparam int B_OVF = 0;
    localparam int FLAG_W = 16;
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] KEEP_OVF = 16'hfffe;

    // temperature, 1/8 degree steps around 25 C
    localparam int TEMP_MIN_C = -60;
    localparam int TEMP_MAX_C = 180;
    localparam int TEMP_OFS_C = 25;
    localparam int TEMP_STEPS_PER_C = 8;
    localparam logic signed [13:0] TEMP_LO =
        14'((TEMP_MIN_C - TEMP_OFS_C) * TEMP_STEPS_PER_C);
    localparam logic signed [13:0] TEMP_HI =
        14'((TEMP_MAX_C - TEMP_OFS_C) * TEMP_STEPS_PER_C);

    // low-power rotation limit, angle full scale 4096
    localparam int ROT_LIMIT_DEG = 135;
    localparam int ANGLE_FULL = 4096;
    localparam logic [11:0] ROT_LIMIT =
        12'(ROT_LIMIT_DEG * ANGLE_FULL / 360);

    // field refresh period
    localparam int CLK_PERIOD_NS = 25;
    localparam int FIELD_PERIOD_US = 128;
    localparam int FIELD_PERIOD_CYC =
        FIELD_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // turns counter limits in both resolutions
    localparam logic signed [11:0] TURN_MAX_HALF = 12'sd511;
    localparam logic signed [11:0] TURN_MIN_HALF = -12'sd512;
    localparam logic signed [11:0] TURN_MAX_FINE = 12'sd2047;
    localparam logic signed [11:0] TURN_MIN_FINE = -12'sd2048;

    localparam int SPI_FRAME_BITS = 16;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;

    typedef logic [15:0] asw_word_t;
endpackage

// *** design/asw_flag_if.sv ***
`timescale 1ns/1ps
interface asw_flag_if;
    logic [15:0] setVec;
    logic [15:0] clrVec;
    logic [15:0] flags;
    modport owner (input setVec, input clrVec, output flags);
    modport user (output setVec, output clrVec, input flags);
endinterface

// *** design/asw_flag_bank.sv ***
`timescale 1ns/1ps
module asw_flag_bank
    import asw_pkg::*;
#(
    parameter int W = FLAG_W
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // flag control
    asw_flag_if.owner fi
);
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_flag
            always_ff @(posedge mclk)
            begin
                if (rst)
                    fi.flags[i] <= FLAGS_RST[i];
                // set beats clear so no event is lost
                else if (fi.setVec[i])
                    fi.flags[i] <= 1'b1;
                else if (fi.clrVec[i])
                    fi.flags[i] <= 1'b0;
            end
        end
    endgenerate

    AST_SET_LATCHES: assert property (@(posedge mclk) disable iff (rst)
        (fi.setVec != 16'h0000) |=>
        ((fi.flags & $past(fi.setVec)) == $past(fi.setVec)))
        else $error("set event did not latch its flag");

    AST_HOLD_FLAGS: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> (($past(fi.flags) & ~$past(fi.clrVec) & ~fi.flags)
        == 16'h0000))
        else $error("flag dropped without a clear");
endmodule

// *** design/asw_status_regs.sv ***
`timescale 1ns/1ps
module asw_status_regs
    import asw_pkg::*;
#(
    parameter int FIELD_CYC = FIELD_PERIOD_CYC,
    parameter int FRAME_BITS = SPI_FRAME_BITS
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register read port
    input wire logic rdReq,
    input wire logic [7:0] rdAddr,
    output logic [15:0] rdData_q,
    output logic rdValid_q,
    // explicit flag clear and turns reset command
    input wire logic clrReq,
    input wire logic [15:0] clrMask,
    input wire logic turnReset,
    // spi framing
    input wire logic spiPktDone,
    input wire logic [5:0] spiBitCnt,
    input wire logic spiMosiMsb,
    input wire logic spiCrcOk,
    input wire logic spiCrcCheckEn,
    input wire logic manchesterErr,
    output logic spiPktAccept_q,
    // extended access
    input wire logic extStart,
    input wire logic extBusy,
    input wire logic extCmdDone,
    input wire logic extUnlocked,
    input wire logic eepromWrFail,
    // measurements
    input wire logic tempValid,
    input wire logic signed [13:0] tempRaw,
    input wire logic [11:0] fieldIn,
    input wire logic [11:0] strongFieldLimit,
    input wire logic signalClipped,
    input wire logic eeLoadDone,
    input wire logic eeSingleFix,
    // low power rotation check
    input wire logic sleepMode,
    input wire logic awakeValid,
    input wire logic [11:0] awakeAngle,
    // turns counter
    input wire logic turnUp,
    input wire logic turnDn,
    input wire logic turnFine,
    // encoder slew limiting
    input wire logic rateLimitEn,
    input wire logic [7:0] slewPeriod,
    input wire logic [11:0] encTarget,
    output logic [11:0] encPos_q,
    // summaries
    input wire logic [15:0] warnMask,
    input wire logic errUnmasked,
    output logic warnSummary_q,
    output logic errorIndicator_q
);
    asw_flag_if fi ();

    asw_flag_bank #(.W(FLAG_W)) u_flags (
        .mclk(mclk),
        .rst(rst),
        .fi(fi.owner)
    );

    logic frameBad;
    logic crcBad;
    logic extFail;
    logic tempLow;
    logic tempHigh;
    logic rotJump;
    logic fieldTick;
    logic fieldHigh;
    logic turnOvf;
    logic slewTick;
    logic slewNeeded;
    logic [11:0] angDiff;
    logic [11:0] angDist;
    logic signed [11:0] turnMax;
    logic signed [11:0] turnMin;
    logic [11:0] tempWord_q;
    logic [11:0] fieldWord_q;
    logic signed [11:0] turnCnt_q;
    logic [11:0] lastAngle_q;
    logic haveLast_q;
    logic [15:0] fieldCnt_q;
    logic [7:0] slewCnt_q;
    logic [11:0] encGap;

    // bad framing wins over crc: only a well-formed packet is checked
    assign frameBad = spiPktDone &&
        ((spiBitCnt != 6'(FRAME_BITS)) || spiMosiMsb);
    assign crcBad = spiPktDone && !frameBad
        && spiCrcCheckEn && !spiCrcOk;
    assign extFail = extCmdDone && (!extUnlocked || eepromWrFail);
    assign tempLow = tempRaw < TEMP_LO;
    assign tempHigh = tempRaw > TEMP_HI;

    // shortest circular distance between awake samples
    assign angDiff = awakeAngle - lastAngle_q;
    assign angDist = angDiff[11] ? 12'(~angDiff + 12'h001) : angDiff;
    assign rotJump = sleepMode && awakeValid && haveLast_q
        && (angDist > ROT_LIMIT);

    assign fieldTick = (fieldCnt_q == 16'(FIELD_CYC - 1));
    assign fieldHigh = fieldTick && (fieldIn > strongFieldLimit);

    assign turnMax = turnFine ? TURN_MAX_FINE : TURN_MAX_HALF;
    assign turnMin = turnFine ? TURN_MIN_FINE : TURN_MIN_HALF;
    assign turnOvf = !turnReset && ((turnUp && !turnDn && turnCnt_q == turnMax)
        || (turnDn && !turnUp && turnCnt_q == turnMin));

    assign slewTick = (slewCnt_q == 8'h00);
    assign encGap = (encTarget > encPos_q) ? 12'(encTarget - encPos_q)
        : 12'(encPos_q - encTarget);
    assign slewNeeded = rateLimitEn && slewTick && (encGap > 12'h001);

    always_comb
    begin
        fi.setVec = 16'h0000;
        fi.setVec[B_IFACE] = frameBad || manchesterErr;
        fi.setVec[B_CRC] = crcBad;
        fi.setVec[B_ZERO] = 1'b0;
        fi.setVec[B_RATE] = slewNeeded;
        fi.setVec[B_EXT] = extFail;
        fi.setVec[B_TEMP] = tempValid && (tempLow || tempHigh);
        fi.setVec[B_EE] = eeLoadDone && eeSingleFix;
        fi.setVec[B_CLIP] = signalClipped;
        fi.setVec[B_ROT] = rotJump;
        fi.setVec[B_BUSY] = extStart && extBusy;
        fi.setVec[B_FIELD] = fieldHigh;
        fi.setVec[B_OVF] = turnOvf;
    end

    // host clear never reaches the overflow flag
    always_comb
    begin
        fi.clrVec = clrReq ? (clrMask & KEEP_OVF) : 16'h0000;
        fi.clrVec[B_OVF] = turnReset;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            spiPktAccept_q <= 1'b0;
        else
            spiPktAccept_q <= spiPktDone && !frameBad && !crcBad;
    end

    // temperature word saturates at the range edges
    always_ff @(posedge mclk)
    begin
        if (rst)
            tempWord_q <= 12'h000;
        else if (tempValid)
        begin
            if (tempLow)
                tempWord_q <= TEMP_LO[11:0];
            else if (tempHigh)
                tempWord_q <= TEMP_HI[11:0];
            else
                tempWord_q <= tempRaw[11:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst || fieldTick)
            fieldCnt_q <= 16'h0000;
        else
            fieldCnt_q <= fieldCnt_q + 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            fieldWord_q <= 12'h000;
        else if (fieldTick)
            fieldWord_q <= fieldIn;
    end

    // previous awake angle forgotten when leaving sleep mode
    always_ff @(posedge mclk)
    begin
        if (rst || !sleepMode)
        begin
            lastAngle_q <= 12'h000;
            haveLast_q <= 1'b0;
        end
        else if (awakeValid)
        begin
            lastAngle_q <= awakeAngle;
            haveLast_q <= 1'b1;
        end
    end

    // counter holds at the limit once overflowed
    always_ff @(posedge mclk)
    begin
        if (rst || turnReset)
            turnCnt_q <= 12'sh000;
        else if (turnUp && !turnDn && turnCnt_q != turnMax)
            turnCnt_q <= turnCnt_q + 12'sh001;
        else if (turnDn && !turnUp && turnCnt_q != turnMin)
            turnCnt_q <= turnCnt_q - 12'sh001;
    end

    always_ff @(posedge mclk)
    begin
        if (rst || slewTick)
            slewCnt_q <= slewPeriod;
        else
            slewCnt_q <= slewCnt_q - 8'h01;
    end

    // limited encoder moves one count per slew period
    always_ff @(posedge mclk)
    begin
        if (rst)
            encPos_q <= 12'h000;
        else if (!rateLimitEn)
            encPos_q <= encTarget;
        else if (slewTick && encTarget > encPos_q)
            encPos_q <= encPos_q + 12'h001;
        else if (slewTick && encTarget < encPos_q)
            encPos_q <= encPos_q - 12'h001;
    end

    function automatic asw_word_t readWord(input logic [7:0] a,
        input logic [15:0] fl);
        logic [14:0] t;
        begin
            t = {ID_TURNS, 12'(turnCnt_q)};
            unique case (a)
                OFS_CAUTION: readWord = {ID_CAUTION, fl[11:0]};
                OFS_TEMP: readWord = {ID_TEMP, tempWord_q};
                OFS_FIELD: readWord = {ID_FIELD, fieldWord_q};
                OFS_TURNS: readWord = {t[14:12], ~^t, t[11:0]};
                default: readWord = RD_UNMAPPED;
            endcase
        end
    endfunction

    // no register writes: the host clears flags through clrReq and clrMask, and the overflow flag only through turnReset
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdData_q <= 16'h0000;
            rdValid_q <= 1'b0;
        end
        else
        begin
            rdValid_q <= rdReq;
            if (rdReq)
                rdData_q <= readWord(rdAddr, fi.flags);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            warnSummary_q <= 1'b0;
            errorIndicator_q <= 1'b0;
        end
        else
        begin
            warnSummary_q <= |(fi.flags & ~warnMask);
            errorIndicator_q <= errUnmasked
                || |(fi.flags & ~warnMask);
        end
    end

    AST_IFACE_FLAG: assert property (@(posedge mclk) disable iff (rst)
        (spiPktDone && spiMosiMsb) |=> fi.flags[B_IFACE] && !spiPktAccept_q)
        else $error("msb-set packet not discarded and flagged");

    AST_CRC_FLAG: assert property (@(posedge mclk) disable iff (rst)
        (spiPktDone && !spiCrcCheckEn && !spiMosiMsb
        && spiBitCnt == 6'(FRAME_BITS)) |=> spiPktAccept_q)
        else $error("crc checked while check disabled");

    AST_TEMP_CLAMP: assert property (@(posedge mclk) disable iff (rst)
        (tempValid && tempRaw > TEMP_HI) |=>
        (tempWord_q == TEMP_HI[11:0]) && fi.flags[B_TEMP])
        else $error("high temperature not saturated");

    AST_CAUTION_ID: assert property (@(posedge mclk) disable iff (rst)
        (rdReq && rdAddr == OFS_CAUTION) |=> rdValid_q
        && rdData_q[15:12] == 4'hb && rdData_q[9] == 1'b0)
        else $error("caution word id or bit9 wrong");

    AST_TURNS_WORD: assert property (@(posedge mclk) disable iff (rst)
        (rdReq && rdAddr == OFS_TURNS) |=>
        (^rdData_q) && rdData_q[15:13] == 3'h6)
        else $error("turns word parity or id wrong");

    AST_OVF_STICKY: assert property (@(posedge mclk) disable iff (rst)
        (fi.flags[B_OVF] && !turnReset) |=> fi.flags[B_OVF])
        else $error("overflow flag cleared without turns reset");

    AST_FIELD_HIGH: assert property (@(posedge mclk) disable iff (rst)
        fieldHigh |=> fi.flags[B_FIELD] && fieldWord_q == $past(fieldIn))
        else $error("strong field not flagged");

    AST_SUMMARY: assert property (@(posedge mclk) disable iff (rst)
        ((fi.flags & ~warnMask) != 16'h0000) |=> warnSummary_q
        && errorIndicator_q)
        else $error("unmasked caution not summarised");

    AST_BUSY: assert property (@(posedge mclk) disable iff (rst)
        (extStart && extBusy) |=> fi.flags[B_BUSY])
        else $error("extended overrun not flagged");

    COV_OVF: cover property (@(posedge mclk) disable iff (rst)
        turnOvf ##1 turnReset);
    COV_ROT: cover property (@(posedge mclk) disable iff (rst) rotJump);
    COV_CRC: cover property (@(posedge mclk) disable iff (rst) crcBad);
    COV_SLEW: cover property (@(posedge mclk) disable iff (rst)
        slewNeeded ##1 fi.flags[B_RATE]);
endmodule

// *** tb/asw_host_model.sv ***
`timescale 1ns/1ps
// host side of the status bank, one access at a time
module asw_host_model
(
    // clock
    input wire logic mclk,
    // read port
    output logic rdReq,
    output logic [7:0] rdAddr,
    input wire logic [15:0] rdData_q,
    input wire logic rdValid_q,
    // clear port
    output logic clrReq,
    output logic [15:0] clrMask
);
    initial
    begin
        rdReq = 1'b0;
        rdAddr = 8'h00;
        clrReq = 1'b0;
        clrMask = 16'h0000;
    end

    // word taken only with valid, so a dead read shows as unknown
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(negedge mclk);
        rdReq = 1'b1;
        rdAddr = a;
        @(negedge mclk);
        rdReq = 1'b0;
        rdAddr = ~a;
        d = rdValid_q ? rdData_q : 16'hxxxx;
    endtask

    task automatic clear(input logic [15:0] m);
        @(negedge mclk);
        clrReq = 1'b1;
        clrMask = m;
        @(negedge mclk);
        clrReq = 1'b0;
        clrMask = ~m;
    endtask
endmodule

// *** tb/test_angle_sensor_warning_status_regs.sv ***
`timescale 1ns/1ps
module test_angle_sensor_warning_status_regs;
    import asw_pkg::*;
    logic mclk = 1'b0, rst = 1'b1;
    logic rdReq, rdValid_q, clrReq, spiPktAccept_q;
    logic [7:0] rdAddr;
    logic [15:0] rdData_q, clrMask, w;
    logic turnReset = 0, spiPktDone = 0, spiMosiMsb = 0, spiCrcOk = 1;
    logic spiCrcCheckEn = 0, manchesterErr = 0, extStart = 0, extBusy = 0;
    logic extCmdDone = 0, extUnlocked = 0, eepromWrFail = 0, tempValid = 0;
    logic signalClipped = 0, eeLoadDone = 0, eeSingleFix = 0, acc;
    logic sleepMode = 0, awakeValid = 0, turnUp = 0, turnDn = 0;
    logic turnFine = 0, rateLimitEn = 0, errUnmasked = 0;
    logic warnSummary_q, errorIndicator_q;
    logic [5:0] spiBitCnt = 6'h10;
    logic signed [13:0] tempRaw = 14'sh0000;
    logic [11:0] fieldIn = 12'h000, strongFieldLimit = 12'h4b0;
    logic [11:0] awakeAngle = 12'h000, encTarget = 12'h000, encPos_q;
    logic [7:0] slewPeriod = 8'h00;
    logic [15:0] warnMask = 16'h0000;
    int errorCnt = 0, totalChecks = 0, cycles = 0;

    always #12.5 mclk = ~mclk;

    asw_host_model asw_host_model_i (.mclk, .rdReq, .rdAddr, .rdData_q,
        .rdValid_q, .clrReq, .clrMask);

    asw_status_regs #(.FIELD_CYC(8)) asw_status_regs_i (.mclk, .rst,
        .rdReq, .rdAddr, .rdData_q, .rdValid_q, .clrReq, .clrMask,
        .turnReset, .spiPktDone, .spiBitCnt, .spiMosiMsb, .spiCrcOk,
        .spiCrcCheckEn, .manchesterErr, .spiPktAccept_q, .extStart,
        .extBusy, .extCmdDone, .extUnlocked, .eepromWrFail, .tempValid,
        .tempRaw, .fieldIn, .strongFieldLimit, .signalClipped, .eeLoadDone,
        .eeSingleFix, .sleepMode, .awakeValid, .awakeAngle, .turnUp,
        .turnDn, .turnFine, .rateLimitEn, .slewPeriod, .encTarget,
        .encPos_q, .warnMask, .errUnmasked, .warnSummary_q,
        .errorIndicator_q);

    task automatic stopTest;
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // whole run is under 9000 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errorCnt++;
            stopTest();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        asw_host_model_i.read(a, w);
    endtask

    task automatic fl(input logic [15:0] bits);
        rd(OFS_CAUTION);
        chk(w, 16'hb000 | bits);
    endtask

    task automatic clr;
        asw_host_model_i.clear(16'hffff);
    endtask

    // accept pulse is sampled at the negedge right after its edge
    task automatic pkt;
        pulse(spiPktDone);
        acc = spiPktAccept_q;
    endtask

    task automatic done(input string s);
        clr();
        $display("test %s finished", s);
    endtask

    task automatic t_ids;
        fl(16'h0000);
        rd(OFS_TEMP);
        chk(w, 16'hf000);
        rd(OFS_FIELD);
        chk(w, 16'he000);
        rd(OFS_TURNS);
        chk(w, 16'hd000);
        rd(8'h30);
        chk(w, 16'h0000);
        done("ids");
    endtask

    task automatic t_spi;
        spiMosiMsb = 1'b1;
        pkt();
        chk({15'h0, acc}, 16'h0000);
        fl(16'h0800);
        chk({15'h0, warnSummary_q}, 16'h0001);
        clr();
        cyc(3);
        chk({15'h0, warnSummary_q}, 16'h0000);
        fl(16'h0000);
        spiMosiMsb = 1'b0;
        spiBitCnt = 6'h0f;
        pkt();
        chk({15'h0, acc}, 16'h0000);
        fl(16'h0800);
        spiBitCnt = 6'h10;
        clr();
        pulse(manchesterErr);
        fl(16'h0800);
        clr();
        pkt();
        chk({15'h0, acc}, 16'h0001);
        spiCrcOk = 1'b0;
        pkt();
        chk({15'h0, acc}, 16'h0001);
        fl(16'h0000);
        spiCrcCheckEn = 1'b1;
        pkt();
        chk({15'h0, acc}, 16'h0000);
        fl(16'h0400);
        spiCrcOk = 1'b1;
        spiCrcCheckEn = 1'b0;
        done("spi");
    endtask

    task automatic t_events;
        pulse(extCmdDone);
        fl(16'h0080);
        clr();
        extUnlocked = 1'b1;
        eepromWrFail = 1'b1;
        pulse(extCmdDone);
        fl(16'h0080);
        clr();
        eepromWrFail = 1'b0;
        pulse(extCmdDone);
        fl(16'h0000);
        pulse(extStart);
        fl(16'h0000);
        extBusy = 1'b1;
        pulse(extStart);
        fl(16'h0004);
        extBusy = 1'b0;
        clr();
        eeSingleFix = 1'b1;
        pulse(eeLoadDone);
        fl(16'h0020);
        eeSingleFix = 1'b0;
        clr();
        signalClipped = 1'b1;
        cyc(2);
        clr();
        fl(16'h0010);
        chk({15'h0, errorIndicator_q}, 16'h0001);
        warnMask = 16'h0010;
        cyc(3);
        chk({15'h0, warnSummary_q}, 16'h0000);
        chk({15'h0, errorIndicator_q}, 16'h0000);
        errUnmasked = 1'b1;
        cyc(3);
        chk({15'h0, errorIndicator_q}, 16'h0001);
        errUnmasked = 1'b0;
        warnMask = 16'h0000;
        signalClipped = 1'b0;
        clr();
        fl(16'h0000);
        done("events");
    endtask

    task automatic t_temp;
        tempRaw = 14'sd2000;
        pulse(tempValid);
        rd(OFS_TEMP);
        chk(w, 16'hf4d8);
        fl(16'h0040);
        clr();
        tempRaw = -14'sd800;
        pulse(tempValid);
        rd(OFS_TEMP);
        chk(w, 16'hfd58);
        clr();
        tempRaw = 14'sd8;
        pulse(tempValid);
        rd(OFS_TEMP);
        chk(w, 16'hf008);
        fl(16'h0000);
        done("temp");
    endtask

    task automatic t_field;
        fieldIn = 12'h4b0;
        cyc(12);
        rd(OFS_FIELD);
        chk(w, 16'he4b0);
        fl(16'h0000);
        fieldIn = 12'h4b1;
        cyc(12);
        rd(OFS_FIELD);
        chk(w, 16'he4b1);
        fl(16'h0002);
        fieldIn = 12'h100;
        cyc(12);
        done("field");
    endtask

    task automatic t_turns;
        repeat (512) pulse(turnUp);
        rd(OFS_TURNS);
        chk(w, 16'hc1ff);
        fl(16'h0001);
        clr();
        fl(16'h0001);
        pulse(turnReset);
        fl(16'h0000);
        repeat (513) pulse(turnDn);
        rd(OFS_TURNS);
        chk(w, 16'hce00);
        fl(16'h0001);
        pulse(turnReset);
        turnFine = 1'b1;
        repeat (2048) pulse(turnUp);
        rd(OFS_TURNS);
        chk(w, 16'hc7ff);
        fl(16'h0001);
        pulse(turnReset);
        rd(OFS_TURNS);
        chk(w, 16'hd000);
        done("turns");
    endtask

    task automatic t_motion;
        sleepMode = 1'b1;
        pulse(awakeValid);
        awakeAngle = 12'd1536;
        pulse(awakeValid);
        fl(16'h0000);
        awakeAngle = 12'd3073;
        pulse(awakeValid);
        fl(16'h0008);
        sleepMode = 1'b0;
        clr();
        // outside sleep mode a large jump must not warn
        awakeAngle = 12'd0;
        pulse(awakeValid);
        fl(16'h0000);
        // one step every slewPeriod + 1 cycles
        rateLimitEn = 1'b1;
        slewPeriod = 8'h03;
        encTarget = 12'd10;
        cyc(2);
        chk({4'h0, encPos_q}, 16'h0001);
        cyc(8);
        chk({4'h0, encPos_q}, 16'h0003);
        cyc(32);
        chk({4'h0, encPos_q}, 16'h000a);
        fl(16'h0100);
        rateLimitEn = 1'b0;
        clr();
        encTarget = 12'd100;
        cyc(2);
        chk({4'h0, encPos_q}, 16'h0064);
        fl(16'h0000);
        done("motion");
    endtask

    initial
    begin
        cyc(10);
        rst = 1'b0;
        cyc(1);
        t_ids();
        t_spi();
        t_events();
        t_temp();
        t_field();
        t_turns();
        t_motion();
        stopTest();
    end
endmodule
